// file: rtl/pdb_core.sv
// PWM dead-band delay and auto-shutdown restart slice with register file.
// Assumes all inputs synchronous to sys_clk; the PWM request and shutdown
// cause come from the surrounding capture/compare logic, timerTick from the
// timer.
//
// Behaviour
// - With comparator sync on, shutdown takes effect only at a timer tick.
// - With restart enabled, shutdown status clears itself once the cause ends.
// - With restart disabled, shutdown status holds until software clears it.
// - Each active-going output edge lags by the delay count in instr cycles.
// - Restart bit and delay count read and write freely and reset to zero.
module pdb_core #(
	parameter int CHANNELS = 2,
	parameter int DELAY_WIDTH = 7
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire pdb_pkg::pdb_bus_req_t busReq,
	output pdb_pkg::pdb_bus_rsp_t busRsp,
	input wire pdb_pkg::pdb_shutdown_in_t shutdownIn,
	input wire logic [CHANNELS-1:0] pwmScheduled,
	output logic [CHANNELS-1:0] pwmOut,
	output logic shutdownActive,
	output logic irq
);

	function automatic logic [31:0] zext8(input logic [7:0] value);
		zext8 = {24'h000000, value};
	endfunction : zext8

	// Register file state.
	logic autoRestartEnable;
	logic [DELAY_WIDTH-1:0] activeEdgeDelayCount;
	logic [pdb_pkg::EVENT_COUNT-1:0] eventStatus;
	logic [pdb_pkg::EVENT_COUNT-1:0] eventEnable;
	logic ackPending;
	logic [31:0] readData;
	logic next_autoRestartEnable;
	logic [DELAY_WIDTH-1:0] next_activeEdgeDelayCount;
	logic [pdb_pkg::EVENT_COUNT-1:0] next_eventStatus;
	logic [pdb_pkg::EVENT_COUNT-1:0] next_eventEnable;
	logic next_ackPending;
	logic [31:0] next_readData;
	logic waitReq;
	logic next_waitReq;

	// Shutdown and delay state.
	logic shutdownEventStatus;
	logic next_shutdownEventStatus;
	logic [1:0] prescale;
	logic [1:0] next_prescale;
	logic instrTick;
	logic [CHANNELS-1:0] pwmLevel;
	logic [CHANNELS-1:0] next_pwmLevel;
	logic [DELAY_WIDTH-1:0] delayCnt [CHANNELS];
	logic [DELAY_WIDTH-1:0] next_delayCnt [CHANNELS];
	logic [CHANNELS-1:0] delayArmed;
	logic [CHANNELS-1:0] next_delayArmed;
	localparam logic [DELAY_WIDTH-1:0] DELAY_ONE = DELAY_WIDTH'(1);
	logic irqLevel;

	logic accessNow;
	logic writeNow;
	logic [7:0] wByte;
	logic shutdownTrigger;
	logic shutdownSet;
	logic shutdownClr;

	// Requests are answered one cycle after they appear, so waitrequest is
	// high during the first cycle and low in the second. A write lands only
	// at the edge where waitrequest is low, when the transfer completes.
	assign accessNow = (busReq.read | busReq.write) & ~ackPending;
	assign writeNow = busReq.write & ackPending;
	assign wByte = busReq.writedata[7:0];

	assign shutdownTrigger = shutdownIn.shutdownCause &
		(~shutdownIn.compSyncEnable | shutdownIn.timerTick);
	assign shutdownSet = shutdownTrigger & ~shutdownEventStatus;

	always_comb begin
		next_shutdownEventStatus = shutdownEventStatus;
		shutdownClr = 1'b0;
		if (autoRestartEnable && !shutdownIn.shutdownCause) begin
			shutdownClr = shutdownEventStatus;
		end
		if (!autoRestartEnable && shutdownIn.softwareClear) begin
			shutdownClr = shutdownEventStatus;
		end
		if (shutdownClr) begin
			next_shutdownEventStatus = 1'b0;
		end
		// A new trigger beats a clear in the same cycle.
		if (shutdownTrigger) begin
			next_shutdownEventStatus = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			shutdownEventStatus <= 1'b0;
		end else begin
			shutdownEventStatus <= next_shutdownEventStatus;
		end
	end

	// Instruction-cycle enable: one pulse every four system clocks.
	always_comb begin
		next_prescale = prescale + 2'h1;
		instrTick = (prescale == pdb_pkg::PRESCALE_LAST);
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			prescale <= 2'h0;
		end else begin
			prescale <= next_prescale;
		end
	end

	// Per-channel delay of active-going edges. The prescaler runs free, so
	// the first instruction tick after a request only arms the counter: a
	// partial cycle never counts, and the lag is 4N to 4N+3 system clocks.
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			next_delayCnt[i] = delayCnt[i];
			next_pwmLevel[i] = pwmLevel[i];
			next_delayArmed[i] = delayArmed[i];
			if (shutdownEventStatus || !pwmScheduled[i]) begin
				next_pwmLevel[i] = 1'b0;
				next_delayCnt[i] = activeEdgeDelayCount;
				next_delayArmed[i] = 1'b0;
			end else if (!pwmLevel[i]) begin
				if (delayCnt[i] == '0) begin
					next_pwmLevel[i] = 1'b1;
				end else if (instrTick && !delayArmed[i]) begin
					next_delayArmed[i] = 1'b1;
				end else if (instrTick) begin
					next_delayCnt[i] = delayCnt[i] - 1'b1;
					next_pwmLevel[i] = (delayCnt[i] == DELAY_ONE);
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pwmLevel <= '0;
			delayArmed <= '0;
			for (int i = 0; i < CHANNELS; i++) begin
				delayCnt[i] <= '0;
			end
		end else begin
			pwmLevel <= next_pwmLevel;
			delayArmed <= next_delayArmed;
			for (int i = 0; i < CHANNELS; i++) begin
				delayCnt[i] <= next_delayCnt[i];
			end
		end
	end

	// Register file and Avalon-MM slave.
	always_comb begin
		next_autoRestartEnable = autoRestartEnable;
		next_activeEdgeDelayCount = activeEdgeDelayCount;
		next_eventEnable = eventEnable;
		next_eventStatus = eventStatus;
		next_ackPending = accessNow;
		next_waitReq = ~accessNow;
		next_readData = readData;
		if (writeNow) begin
			unique case (busReq.address)
				pdb_pkg::ADDR_CONTROL: begin
					next_autoRestartEnable = wByte[pdb_pkg::RESTART_BIT];
					next_activeEdgeDelayCount =
						wByte[pdb_pkg::DELAY_MSB:0];
				end
				pdb_pkg::ADDR_IRQ_CLEAR: begin
					next_eventStatus = eventStatus &
						~wByte[pdb_pkg::EVENT_COUNT-1:0];
				end
				pdb_pkg::ADDR_IRQ_ENABLE: begin
					next_eventEnable = wByte[pdb_pkg::EVENT_COUNT-1:0];
				end
				default: begin
				end
			endcase
		end
		// Hardware events are set after the clear so a set wins.
		if (shutdownSet) begin
			next_eventStatus[pdb_pkg::EVT_SHUTDOWN] = 1'b1;
		end
		if (shutdownClr && !shutdownTrigger) begin
			next_eventStatus[pdb_pkg::EVT_RESTART] = 1'b1;
		end
		if (accessNow && busReq.read) begin
			unique case (busReq.address)
				pdb_pkg::ADDR_CONTROL:
					next_readData = zext8({autoRestartEnable,
						activeEdgeDelayCount});
				pdb_pkg::ADDR_STATUS:
					next_readData = zext8({4'h0, eventStatus,
						shutdownIn.compSyncEnable, shutdownEventStatus});
				pdb_pkg::ADDR_IRQ_ENABLE:
					next_readData = zext8({6'h00, eventEnable});
				default:
					next_readData = zext8(pdb_pkg::UNMAPPED_READ);
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			autoRestartEnable <= 1'b0;
			activeEdgeDelayCount <= '0;
			eventStatus <= '0;
			eventEnable <= '0;
			ackPending <= 1'b0;
			waitReq <= 1'b1;
			readData <= 32'h00000000;
		end else begin
			autoRestartEnable <= next_autoRestartEnable;
			activeEdgeDelayCount <= next_activeEdgeDelayCount;
			eventStatus <= next_eventStatus;
			eventEnable <= next_eventEnable;
			ackPending <= next_ackPending;
			waitReq <= next_waitReq;
			readData <= next_readData;
		end
	end

	assign irqLevel = |(next_eventStatus & next_eventEnable);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= irqLevel;
		end
	end

	always_comb begin
		busRsp.readdata = readData;
		busRsp.waitrequest = waitReq;
		pwmOut = pwmLevel;
		shutdownActive = shutdownEventStatus;
	end

	// Assertions.
	sequence activeRequest(int ch);
		pwmScheduled[ch] && !shutdownEventStatus;
	endsequence

	shutdown_sync_gate_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(!shutdownEventStatus && shutdownIn.compSyncEnable &&
		!shutdownIn.timerTick) |=> !shutdownEventStatus)
		else $error("shutdown taken without timer tick");

	sync_tick_shutdown_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(shutdownIn.shutdownCause && shutdownIn.compSyncEnable &&
		shutdownIn.timerTick) |=> shutdownEventStatus)
		else $error("shutdown missed at timer tick");

	auto_restart_clear_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(shutdownEventStatus && autoRestartEnable &&
		!shutdownIn.shutdownCause) |=> !shutdownEventStatus)
		else $error("auto restart did not clear status");

	manual_status_hold_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(shutdownEventStatus && !autoRestartEnable &&
		!shutdownIn.softwareClear) |=> shutdownEventStatus)
		else $error("status cleared without software");

	shutdown_forces_low_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		shutdownEventStatus |=> pwmLevel == '0)
		else $error("output active during shutdown");

	zero_delay_edge_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(activeRequest(0) and (!pwmLevel[0] && delayCnt[0] == '0)) |=>
		pwmLevel[0])
		else $error("zero delay edge late");

	inactive_edge_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!pwmScheduled[0] |=> !pwmLevel[0])
		else $error("inactive edge delayed");

	delay_count_step_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(activeRequest(0) and (!pwmLevel[0] && delayCnt[0] != '0 &&
		delayArmed[0] && instrTick)) |=>
		delayCnt[0] == $past(delayCnt[0]) - 1'b1)
		else $error("delay counter did not step");

	last_step_rise_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(activeRequest(0) and (!pwmLevel[0] && delayArmed[0] &&
		instrTick && delayCnt[0] == DELAY_ONE)) |=> pwmLevel[0])
		else $error("output late after last delay step");

	delay_holds_low_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(!pwmLevel[0] && delayCnt[0] != '0 &&
		!(delayArmed[0] && instrTick && delayCnt[0] == DELAY_ONE)) |=>
		!pwmLevel[0])
		else $error("output went active before delay");

	control_write_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(writeNow && busReq.address == pdb_pkg::ADDR_CONTROL) |=>
		{autoRestartEnable, activeEdgeDelayCount} ==
		$past(busReq.writedata[7:0]))
		else $error("control write not stored");

	bus_answer_a: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		accessNow |=> !busRsp.waitrequest ##1 busRsp.waitrequest)
		else $error("bus answer not one cycle");

endmodule : pdb_core

// file: rtl/pdb_pkg.sv
// Package for the PWM dead-band and restart slice: register map, fields,
// reset values and the packed carriers used at the top-level ports.
// Assumes a 100 MHz system clock and an Avalon-MM register bus.
package pdb_pkg;

	// Register byte addresses on the Avalon-MM bus (word aligned).
	localparam logic [3:0] ADDR_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h8;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hC;

	// Control register fields.
	localparam int RESTART_BIT = 7;
	localparam int DELAY_MSB = 6;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// Status register bits: bit 0 shows the live shutdown status.
	localparam int ST_SHUTDOWN = 0;
	localparam int ST_SYNC = 1;
	localparam int EVT_SHUTDOWN = 0;
	localparam int EVT_RESTART = 1;
	localparam int EVENT_COUNT = 2;

	// One instruction cycle spans four oscillator periods.
	localparam int OSC_PER_INSTR = 4;
	localparam logic [1:0] PRESCALE_LAST = 2'h3;

	// Value returned by reads of unmapped addresses.
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} pdb_bus_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} pdb_bus_rsp_t;

	typedef struct packed {
		logic shutdownCause;
		logic compSyncEnable;
		logic timerTick;
		logic softwareClear;
	} pdb_shutdown_in_t;

endpackage : pdb_pkg

// file: sim/tb_top.sv
// Self-checking bench for the PWM delay and restart slice.
// Assumes pdb_core with its default two channels; the bench drives every
// port itself and speaks the Avalon-MM register protocol.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk;
	logic rst_b;
	pdb_pkg::pdb_bus_req_t busReq;
	pdb_pkg::pdb_bus_rsp_t busRsp;
	pdb_pkg::pdb_shutdown_in_t sdIn;
	logic [1:0] pwmScheduled;
	logic [1:0] pwmOut;
	logic shutdownActive;
	logic irq;
	int miscompares = 0;
	int n_tests = 0;
	logic [7:0] rdData;
	logic [7:0] delays[4] = '{8'h00, 8'h01, 8'h05, 8'h7F};
	int i;
	int lo;

	pdb_core u_pdb_core (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.busReq(busReq),
		.busRsp(busRsp),
		.shutdownIn(sdIn),
		.pwmScheduled(pwmScheduled),
		.pwmOut(pwmOut),
		.shutdownActive(shutdownActive),
		.irq(irq)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic close_out;
		if (miscompares == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	task automatic check(input logic [7:0] got, input logic [7:0] want);
		n_tests++;
		if (got !== want) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : step

	// The extra edge after release keeps two requests from being driven
	// in the same time step.
	task automatic access(input logic [3:0] a, input logic w,
		input logic [7:0] d);
		int k;
		busReq <= '{address: a, read: !w, write: w, writedata: {24'h0, d}};
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (busRsp.waitrequest !== 1'b0 && k < 40);
		if (k >= 40) begin
			miscompares++;
			close_out();
		end
		rdData = busRsp.readdata[7:0];
		busReq <= '0;
		@(posedge sys_clk);
	endtask : access

	task automatic rdc(input logic [3:0] a, input logic [7:0] want);
		access(a, 1'b0, 8'h00);
		check(rdData, want);
	endtask : rdc

	initial begin
		rst_b = 1'b0;
		busReq = '0;
		sdIn = '0;
		pwmScheduled = 2'h0;
		step(12);
		rst_b <= 1'b1;
		step(1);
		rdc(4'h0, 8'h00);
		rdc(4'h4, 8'h00);
		rdc(4'hC, 8'h00);
		rdc(4'h2, 8'h00);
		access(4'h0, 1'b1, 8'h85);
		rdc(4'h0, 8'h85);
		access(4'h4, 1'b1, 8'hFF);
		rdc(4'h4, 8'h00);
		foreach (delays[j]) begin
			access(4'h0, 1'b1, delays[j]);
			// A lag of N instruction cycles is 4N to 4N+3 clocks; two more
			// edges pass before the registered output is seen here.
			lo = 4 * delays[j] + 2;
			pwmScheduled <= 2'h1;
			i = 0;
			do begin
				@(posedge sys_clk);
				i++;
			end while (pwmOut[0] !== 1'b1 && i < 600);
			check(8'(i >= lo && i <= lo + 3), 8'h01);
			if (i >= 600) begin
				close_out();
			end
			pwmScheduled <= 2'h0;
			step(2);
			check({6'h0, pwmOut}, 8'h00);
		end
		access(4'h0, 1'b1, 8'h00);
		access(4'hC, 1'b1, 8'h03);
		pwmScheduled <= 2'h3;
		step(4);
		sdIn.shutdownCause <= 1'b1;
		step(2);
		check({7'h0, shutdownActive}, 8'h01);
		sdIn.shutdownCause <= 1'b0;
		step(2);
		check({6'h0, pwmOut}, 8'h00);
		check({7'h0, irq}, 8'h01);
		rdc(4'h4, 8'h05);
		access(4'hC, 1'b1, 8'h00);
		step(1);
		check({7'h0, irq}, 8'h00);
		sdIn.softwareClear <= 1'b1;
		step(1);
		sdIn.softwareClear <= 1'b0;
		step(1);
		check({7'h0, shutdownActive}, 8'h00);
		step(5);
		check({6'h0, pwmOut}, 8'h03);
		rdc(4'h4, 8'h0C);
		access(4'h8, 1'b1, 8'h03);
		rdc(4'h4, 8'h00);
		access(4'h0, 1'b1, 8'h80);
		sdIn.shutdownCause <= 1'b1;
		step(2);
		check({7'h0, shutdownActive}, 8'h01);
		sdIn.shutdownCause <= 1'b0;
		step(2);
		check({7'h0, shutdownActive}, 8'h00);
		access(4'h8, 1'b1, 8'h03);
		sdIn.compSyncEnable <= 1'b1;
		sdIn.shutdownCause <= 1'b1;
		step(6);
		check({7'h0, shutdownActive}, 8'h00);
		rdc(4'h4, 8'h02);
		sdIn.timerTick <= 1'b1;
		step(1);
		sdIn.timerTick <= 1'b0;
		step(1);
		check({7'h0, shutdownActive}, 8'h01);
		sdIn <= '0;
		rst_b <= 1'b0;
		step(2);
		check({7'h0, shutdownActive}, 8'h00);
		rst_b <= 1'b1;
		step(1);
		rdc(4'h0, 8'h00);
		rdc(4'h4, 8'h00);
		close_out();
	end
endmodule : tb_top
